/* rtl/rss_top.v */
// address decoder, space selection and port registers
// assumes a multiplexed host bus on pins, config bits
// loaded through a small config port before run-time
`include "rss_defines.vh"
module rss_top #(
	parameter MEM_AW = 8
) (
	input wire clk_sys,
	input wire rst,
	// host bus pins
	input wire [15:0] low_addr_data_lines,
	output reg [15:0] ad_out_q,
	output wire ad_oe,
	input wire ale,
	input wire rd_n,
	input wire wr_n,
	input wire program_fetch_strobe_n,
	input wire high_addr_or_enable_pin,
	input wire [2:0] port_c_pins,
	output wire wait_n,
	// decoder selects
	output wire [10:0] decoder_select_outputs,
	output wire [10:0] decoder_select_oe,
	output wire [7:0] eprom_bank_selects,
	output wire sram_select,
	output wire port_space_select,
	output wire periph_input_select,
	output wire periph_output_select_one,
	output wire periph_output_select_two,
	output wire mem_standby,
	// port a
	input wire [7:0] port_a_in,
	output reg [7:0] port_a_out_q,
	output wire [7:0] port_a_oe,
	// configuration and programming side
	input wire [10:0] cfg_cs_open_drain,
	input wire cfg_secure,
	input wire cfg_wr,
	input wire [3:0] cfg_idx,
	input wire [7:0] cfg_wdata,
	input wire prog_rd_req,
	input wire [3:0] prog_rd_idx,
	output reg [7:0] prog_rd_data_q,
	output reg prog_rd_ack_q,
	output reg prog_rd_refused_q,
	output wire secure_locked
);

	// ----------------------------------------
	// pin synchronisers
	// ----------------------------------------
	wire [31:0] pins_s; // synced pins, strobes inverted so reset reads idle
	rss_sync #(
		.WIDTH(32)
	) u_sync (
		.clk_sys(clk_sys),
		.rst(rst),
		.d({port_a_in, low_addr_data_lines, ale, ~rd_n, ~wr_n,
			~program_fetch_strobe_n, high_addr_or_enable_pin,
			port_c_pins}),
		.q(pins_s)
	);

	wire [7:0] pa_s = pins_s[31:24]; // port a input
	wire [15:0] ad_s = pins_s[23:8]; // address/data
	wire ale_s = pins_s[7]; // latch strobe
	wire rd_s = pins_s[6]; // read active
	wire wr_s = pins_s[5]; // write active
	wire fetch_s = pins_s[4]; // program fetch active
	wire [3:0] lin_s = pins_s[3:0]; // logic inputs

	// ----------------------------------------
	// run flag and security latch
	// ----------------------------------------
	reg run_q; // low in reset and first cycle after
	reg secure_q; // caught after reset release
	reg sec_taken_q; // strap already caught

	// catch security once, at configuration time
	always @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			run_q <= 1'b0;
			secure_q <= 1'b0;
			sec_taken_q <= 1'b0;
		end else begin
			run_q <= 1'b1;
			if (!sec_taken_q) begin
				secure_q <= cfg_secure;
				sec_taken_q <= 1'b1;
			end
		end
	end

	assign secure_locked = secure_q;

	// ----------------------------------------
	// configuration store
	// ----------------------------------------
	reg [7:0] cs_page_q [0:10]; // select region keys
	reg [4:0] eprom_base_q; // eprom region key
	reg [7:0] sram_page_q; // sram region key
	reg [7:0] io_page_q; // port space key
	reg [7:0] opt_q; // option bits
	reg [3:0] wait_sel_q; // select used as wait
	integer i;
	integer j; // loop index of the select compare

	// config writes, refused once locked
	always @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			for (i = 0; i < 11; i = i + 1) begin
				cs_page_q[i] <= `RSS_CFG_RESET;
			end
			eprom_base_q <= 5'h00;
			sram_page_q <= `RSS_CFG_RESET;
			io_page_q <= `RSS_CFG_RESET;
			opt_q <= `RSS_CFG_RESET;
			wait_sel_q <= `RSS_WAIT_SEL_RESET;
		end else if (cfg_wr && sec_taken_q && !secure_q) begin
			case (cfg_idx)
				`RSS_CFG_EPROM_BASE: eprom_base_q <= cfg_wdata[4:0];
				`RSS_CFG_SRAM_PAGE: sram_page_q <= cfg_wdata;
				`RSS_CFG_IO_PAGE: io_page_q <= cfg_wdata;
				`RSS_CFG_OPTIONS: opt_q <= cfg_wdata;
				`RSS_CFG_WAIT_SEL: wait_sel_q <= cfg_wdata[3:0];
				default: cs_page_q[cfg_idx] <= cfg_wdata;
			endcase
		end
	end

	wire opt_eprom_rd = opt_q[`RSS_OPT_EPROM_ON_RD]; // eprom on read
	wire opt_sram_prog = opt_q[`RSS_OPT_SRAM_IN_PROG]; // sram in both
	wire opt_track = opt_q[`RSS_OPT_TRACK_A]; // port a tracking
	wire opt_transp = opt_q[`RSS_OPT_TRANSPARENT]; // bypass latch
	wire opt_wait = opt_q[`RSS_OPT_WAIT_EN]; // wait enabled

	// ----------------------------------------
	// programming-side readout
	// ----------------------------------------
	reg [7:0] cfg_rd; // selected config byte

	// config byte mux
	always @* begin
		case (prog_rd_idx)
			`RSS_CFG_EPROM_BASE: cfg_rd = {3'h0, eprom_base_q};
			`RSS_CFG_SRAM_PAGE: cfg_rd = sram_page_q;
			`RSS_CFG_IO_PAGE: cfg_rd = io_page_q;
			`RSS_CFG_OPTIONS: cfg_rd = opt_q;
			`RSS_CFG_WAIT_SEL: cfg_rd = {4'h0, wait_sel_q};
			default: cfg_rd = cs_page_q[prog_rd_idx];
		endcase
	end

	// answer one cycle later, refused when secure
	always @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			prog_rd_data_q <= 8'h00;
			prog_rd_ack_q <= 1'b0;
			prog_rd_refused_q <= 1'b0;
		end else begin
			prog_rd_ack_q <= prog_rd_req && !secure_q;
			prog_rd_refused_q <= prog_rd_req && secure_q;
			if (prog_rd_req && !secure_q) begin
				prog_rd_data_q <= cfg_rd;
			end else begin
				prog_rd_data_q <= 8'h00;
			end
		end
	end

	// ----------------------------------------
	// address latch
	// ----------------------------------------
	reg [15:0] addr_q; // latched low address
	reg [3:0] lin_q; // latched logic inputs
	reg [15:0] addr_prev_q; // address under strobe, inverse when idle

	// transparent while ale high, held after
	always @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			addr_q <= 16'h0000;
			lin_q <= 4'h0;
			addr_prev_q <= 16'h0000;
		end else begin
			if (ale_s) begin
				addr_q <= ad_s;
				lin_q <= lin_s;
			end
			addr_prev_q <= (rd_s | wr_s | fetch_s) ? addr_q : ~addr_q;
		end
	end

	// logic inputs pass through when set so
	wire [3:0] lin_eff = opt_transp ? lin_s : lin_q;
	wire [19:0] addr_full = {lin_eff, addr_q}; // full address
	wire [7:0] key = addr_full[19:12]; // region key

	// ----------------------------------------
	// decode equations
	// ----------------------------------------
	wire data_acc = rd_s | wr_s; // data-space strobe
	wire eprom_str = fetch_s | (opt_eprom_rd & rd_s);
	wire sram_str = data_acc | (opt_sram_prog & fetch_s);
	wire eprom_hit = run_q & eprom_str &
		(key[7:3] == eprom_base_q);
	wire sram_hit = run_q & sram_str & (key == sram_page_q);
	wire port_hit = run_q & data_acc & (key == io_page_q);
	reg [10:0] cs_hit; // active-high select terms

	// per-select region compare
	always @* begin
		for (j = 0; j < 11; j = j + 1) begin
			cs_hit[j] = run_q & (data_acc | fetch_s) &
				(key == cs_page_q[j]);
		end
	end

	// selects inactive until run, then per equations
	assign decoder_select_outputs = ~cs_hit;
	assign eprom_bank_selects = eprom_hit ?
		(8'h01 << key[2:0]) : 8'h00;
	assign sram_select = sram_hit;
	assign port_space_select = port_hit;

	// open-drain bits drive only low; pull-ups outside
	genvar g;
	generate
		for (g = 0; g < 11; g = g + 1) begin : g_cs_oe
			assign decoder_select_oe[g] =
				cfg_cs_open_drain[g] ? cs_hit[g] : 1'b1;
		end
	endgenerate

	// peripheral region is that of the wait select
	wire periph_hit = (wait_sel_q <= `RSS_CFG_CS_LAST) &&
		cs_hit[wait_sel_q];
	assign periph_input_select = periph_hit & rd_s;
	assign periph_output_select_one = periph_hit & wr_s & ~addr_q[0];
	assign periph_output_select_two = periph_hit & wr_s & addr_q[0];
	assign wait_n = ~(opt_wait & periph_hit);

	// ----------------------------------------
	// port register space
	// ----------------------------------------
	reg [7:0] dir_a_q; // port a direction
	reg [7:0] data_a_q; // port a data
	reg [7:0] page_q; // page register
	reg [7:0] power_mode_reg_q; // power mode register
	reg wr_prev_q; // write strobe last cycle
	wire wr_start = wr_s & ~wr_prev_q; // write edge

	// cleared in reset, held until host writes
	always @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			dir_a_q <= `RSS_PREG_RESET;
			data_a_q <= `RSS_PREG_RESET;
			page_q <= `RSS_PREG_RESET;
			power_mode_reg_q <= `RSS_PREG_RESET;
			wr_prev_q <= 1'b0;
		end else begin
			wr_prev_q <= wr_s;
			if (wr_start && port_hit) begin
				case (addr_q[1:0])
					`RSS_PREG_DIR_A: dir_a_q <= ad_s[7:0];
					`RSS_PREG_DATA_A: data_a_q <= ad_s[7:0];
					`RSS_PREG_PAGE: page_q <= ad_s[7:0];
					`RSS_PREG_POWER_MODE: power_mode_reg_q <= ad_s[7:0];
					default: page_q <= page_q;
				endcase
			end
		end
	end

	// ----------------------------------------
	// sram with standby between accesses
	// ----------------------------------------
	wire mem_wake = sram_hit & ((addr_q != addr_prev_q) |
		wr_start);
	wire [7:0] mem_rdata; // latched array output
	rss_mem #(
		.AW(MEM_AW),
		.DW(8)
	) u_mem (
		.clk_sys(clk_sys),
		.rst(rst),
		.en(mem_wake),
		.we(wr_start),
		.addr(addr_q[MEM_AW-1:0]),
		.wdata(ad_s[7:0]),
		.rdata_q(mem_rdata),
		.standby(mem_standby)
	);

	// ----------------------------------------
	// host read data and port a drive
	// ----------------------------------------
	reg [7:0] preg_rd; // port register readback

	// port register mux
	always @* begin
		case (addr_q[1:0])
			`RSS_PREG_DIR_A: preg_rd = dir_a_q;
			`RSS_PREG_DATA_A: preg_rd = data_a_q;
			`RSS_PREG_PAGE: preg_rd = page_q;
			default: preg_rd = power_mode_reg_q;
		endcase
	end

	// registered read data toward the host
	always @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			ad_out_q <= 16'h0000;
			port_a_out_q <= 8'h00;
		end else begin
			if (port_hit) begin
				ad_out_q <= {8'h00, preg_rd};
			end else if (sram_hit) begin
				ad_out_q <= {8'h00, mem_rdata};
			end else if (periph_hit && opt_track) begin
				ad_out_q <= {8'h00, pa_s};
			end
			if (opt_track) begin
				port_a_out_q <= ad_s[7:0];
			end else begin
				port_a_out_q <= data_a_q;
			end
		end
	end

	// drive host bus only on decoded reads
	assign ad_oe = rd_s & (port_hit | sram_hit |
		(periph_hit & opt_track));
	// tracking drives the shared bus on peripheral writes
	assign port_a_oe = opt_track ?
		{8{run_q & periph_hit & wr_s}} : dir_a_q;

endmodule // rss_top

/* rtl/rss_defines.vh */
// constants for the reset, space-select and decoder block
// assumes the includer uses clk_sys at 50 MHz and an active-high reset
`ifndef RSS_DEFINES_VH
`define RSS_DEFINES_VH

// ----------------------------------------
// port register space, offset in low bits
// ----------------------------------------
`define RSS_PREG_DIR_A 2'h0
`define RSS_PREG_DATA_A 2'h1
`define RSS_PREG_PAGE 2'h2
`define RSS_PREG_POWER_MODE 2'h3
`define RSS_PREG_RESET 8'h00

// ----------------------------------------
// configuration entries, by index
// ----------------------------------------
`define RSS_CFG_CS_LAST 4'hA
`define RSS_CFG_EPROM_BASE 4'hB
`define RSS_CFG_SRAM_PAGE 4'hC
`define RSS_CFG_IO_PAGE 4'hD
`define RSS_CFG_OPTIONS 4'hE
`define RSS_CFG_WAIT_SEL 4'hF

// ----------------------------------------
// option bit positions
// ----------------------------------------
`define RSS_OPT_EPROM_ON_RD 0
`define RSS_OPT_SRAM_IN_PROG 1
`define RSS_OPT_TRACK_A 2
`define RSS_OPT_TRANSPARENT 3
`define RSS_OPT_WAIT_EN 4

// ----------------------------------------
// reset values
// ----------------------------------------
`define RSS_CFG_RESET 8'h00
`define RSS_WAIT_SEL_RESET 4'h2
`define RSS_CS_INACTIVE 11'h7FF

`endif

/* rtl/rss_sync.v */
// two-stage synchroniser for a group of pin inputs
// assumes inputs are asynchronous to clk_sys
module rss_sync #(
	parameter WIDTH = 8
) (
	input wire clk_sys,
	input wire rst,
	input wire [WIDTH-1:0] d,
	output wire [WIDTH-1:0] q
);

	// ----------------------------------------
	// flops
	// ----------------------------------------
	reg [WIDTH-1:0] meta_q; // first stage, read only by second
	reg [WIDTH-1:0] sync_q; // second stage

	// two flops per bit
	always @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			meta_q <= {WIDTH{1'b0}};
			sync_q <= {WIDTH{1'b0}};
		end else begin
			meta_q <= d;
			sync_q <= meta_q;
		end
	end

	assign q = sync_q;

endmodule // rss_sync

/* rtl/rss_mem.v */
// small sram array with registered read data and standby
// assumes en is a one-cycle wake pulse from the owner
module rss_mem #(
	parameter AW = 8,
	parameter DW = 8
) (
	input wire clk_sys,
	input wire rst,
	input wire en,
	input wire we,
	input wire [AW-1:0] addr,
	input wire [DW-1:0] wdata,
	output reg [DW-1:0] rdata_q,
	output wire standby
);

	// ----------------------------------------
	// storage
	// ----------------------------------------
	reg [DW-1:0] mem [0:(1<<AW)-1]; // array, not reset

	// write when woken with write
	always @(posedge clk_sys) begin
		if (en && we) begin
			mem[addr] <= wdata;
		end
	end

	// read latched into output register, held in standby
	always @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			rdata_q <= {DW{1'b0}};
		end else if (en && !we) begin
			rdata_q <= mem[addr];
		end
	end

	// array idle except for the wake cycle
	assign standby = ~en;

endmodule // rss_mem

/* verif/rss_monitor.sv */
// checker for the select block, sees top-level ports only
// assumes it is bound into rss_top by the bench
module rss_monitor (
	input wire clk_sys,
	input wire rst,
	input wire rd_n,
	input wire wr_n,
	input wire [10:0] decoder_select_outputs,
	input wire [10:0] decoder_select_oe,
	input wire [10:0] cfg_cs_open_drain,
	input wire [7:0] eprom_bank_selects,
	input wire sram_select,
	input wire port_space_select,
	input wire periph_input_select,
	input wire periph_output_select_one,
	input wire periph_output_select_two,
	input wire mem_standby,
	input wire [7:0] port_a_out_q,
	input wire [15:0] ad_out_q,
	input wire prog_rd_req,
	input wire [7:0] prog_rd_data_q,
	input wire prog_rd_ack_q,
	input wire prog_rd_refused_q,
	input wire secure_locked
);
	timeunit 1ns;
	timeprecision 1ns;
	// ----------------------------------------
	// reset state
	// ----------------------------------------
	property p_rst_cs;
		@(posedge clk_sys) rst |-> decoder_select_outputs == 11'h7FF;
	endproperty
	a_rst_cs: assert property (p_rst_cs)
		else $error("decoder select active in reset");
	property p_rst_int;
		@(posedge clk_sys) rst |-> {sram_select, port_space_select,
			periph_input_select, periph_output_select_one,
			periph_output_select_two, eprom_bank_selects} == 13'h0000;
	endproperty
	a_rst_int: assert property (p_rst_int)
		else $error("internal select active in reset");
	property p_rst_regs;
		@(posedge clk_sys) rst |-> port_a_out_q == 8'h00
			&& ad_out_q == 16'h0000 && !prog_rd_ack_q;
	endproperty
	a_rst_regs: assert property (p_rst_regs)
		else $error("register not cleared in reset");
	// ----------------------------------------
	// readout and lock
	// ----------------------------------------
	property p_rd_ans;
		@(posedge clk_sys) disable iff (rst)
		prog_rd_req && !secure_locked |=> prog_rd_ack_q && !prog_rd_refused_q;
	endproperty
	a_rd_ans: assert property (p_rd_ans)
		else $error("open readout not answered");
	property p_rd_ref;
		@(posedge clk_sys) disable iff (rst)
		prog_rd_req && secure_locked |=> prog_rd_refused_q && !prog_rd_ack_q
			&& prog_rd_data_q == 8'h00;
	endproperty
	a_rd_ref: assert property (p_rd_ref)
		else $error("locked readout not refused");
	property p_lock;
		@(posedge clk_sys) disable iff (rst) secure_locked |=> secure_locked;
	endproperty
	a_lock: assert property (p_lock)
		else $error("lock dropped without reset");
	// ----------------------------------------
	// standby, spaces, select drive
	// ----------------------------------------
	property p_standby;
		@(posedge clk_sys) disable iff (rst) !mem_standby |=> mem_standby;
	endproperty
	a_standby: assert property (p_standby)
		else $error("memory awake two cycles");
	// no data strobe for three samples covers the synchroniser delay
	sequence s_no_data;
		(rd_n && wr_n) [*3];
	endsequence
	property p_no_prog;
		@(posedge clk_sys) disable iff (rst) s_no_data |-> !port_space_select;
	endproperty
	a_no_prog: assert property (p_no_prog)
		else $error("port space without data strobe");
	property p_od;
		@(posedge clk_sys) disable iff (rst)
		((cfg_cs_open_drain & decoder_select_oe & decoder_select_outputs)
		| (~cfg_cs_open_drain & ~decoder_select_oe)) == 11'h000;
	endproperty
	a_od: assert property (p_od)
		else $error("select drive enable wrong");
	property p_onehot;
		@(posedge clk_sys) disable iff (rst) $onehot0(eprom_bank_selects);
	endproperty
	a_onehot: assert property (p_onehot)
		else $error("more than one bank select");
endmodule // rss_monitor

/* verif/rss_host_model.sv */
// host microcontroller on the multiplexed bus, with select pull-ups
// assumes the bench calls access; pins move on falling edges
module rss_host_model (
	input wire clk_sys,
	input wire [10:0] decoder_select_outputs,
	input wire [10:0] decoder_select_oe,
	input wire [7:0] eprom_bank_selects,
	output reg [15:0] low_addr_data_lines,
	output reg ale,
	output reg rd_n,
	output reg wr_n,
	output reg program_fetch_strobe_n,
	output reg high_addr_or_enable_pin,
	output reg [2:0] port_c_pins,
	output wire [10:0] cs_wire
);
	timeunit 1ns;
	timeprecision 1ns;
	// released open-drain selects are lifted by the board
	assign cs_wire = decoder_select_outputs | ~decoder_select_oe;
	// idle bus
	initial begin
		low_addr_data_lines = 16'h0000;
		{ale, rd_n, wr_n, program_fetch_strobe_n} = 4'h7;
		{high_addr_or_enable_pin, port_c_pins} = 4'h0;
	end
	// one bus cycle: latch address, then one strobe
	// kind 0 fetch, 1 data read, 2 data write of wd
	task automatic access(input logic [1:0] kind, input logic [19:0] a,
		input logic [7:0] wd, output logic [7:0] eb);
		@(negedge clk_sys);
		ale = 1'b1;
		low_addr_data_lines = a[15:0];
		{high_addr_or_enable_pin, port_c_pins} = a[19:16];
		repeat (3) @(negedge clk_sys);
		ale = 1'b0;
		// write data, or the released bus shown as the inverse address
		low_addr_data_lines = (kind == 2'h2) ? {8'h00, wd} : ~a[15:0];
		@(negedge clk_sys);
		program_fetch_strobe_n = (kind != 2'h0);
		rd_n = (kind != 2'h1);
		wr_n = (kind != 2'h2);
		repeat (4) @(negedge clk_sys);
		eb = eprom_bank_selects;
		{program_fetch_strobe_n, rd_n, wr_n} = 3'h7;
		repeat (2) @(negedge clk_sys);
	endtask
endmodule // rss_host_model

/* verif/rss_top_tb.sv */
// self-checking bench for rss_top
// assumes rss_host_model and rss_monitor are compiled first
module rss_top_tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk_sys, rst, cfg_secure, cfg_wr, prog_rd_req;
	logic [3:0] cfg_idx, prog_rd_idx;
	logic [7:0] cfg_wdata, port_a_in, eb;
	logic [10:0] cfg_cs_open_drain;
	wire [15:0] low_addr_data_lines, ad_out_q;
	wire ale, rd_n, wr_n, program_fetch_strobe_n, high_addr_or_enable_pin;
	wire [2:0] port_c_pins;
	wire [10:0] cs_wire, decoder_select_outputs, decoder_select_oe;
	wire [7:0] eprom_bank_selects, port_a_out_q, prog_rd_data_q;
	wire sram_select, port_space_select, periph_input_select;
	wire periph_output_select_one, periph_output_select_two;
	wire mem_standby, prog_rd_ack_q, prog_rd_refused_q, secure_locked;
	wire wait_n;
	int miscompares, n_checks, n_wait;
	// selects 3 and 4 open-drain
	assign cfg_cs_open_drain = 11'h018;
	assign port_a_in = 8'hA5;
	rss_top rss_top_i (.clk_sys(clk_sys), .rst(rst),
		.low_addr_data_lines(low_addr_data_lines), .ad_out_q(ad_out_q),
		.ad_oe(), .ale(ale), .rd_n(rd_n), .wr_n(wr_n),
		.program_fetch_strobe_n(program_fetch_strobe_n),
		.high_addr_or_enable_pin(high_addr_or_enable_pin),
		.port_c_pins(port_c_pins), .wait_n(wait_n),
		.decoder_select_outputs(decoder_select_outputs),
		.decoder_select_oe(decoder_select_oe),
		.eprom_bank_selects(eprom_bank_selects), .sram_select(sram_select),
		.port_space_select(port_space_select),
		.periph_input_select(periph_input_select),
		.periph_output_select_one(periph_output_select_one),
		.periph_output_select_two(periph_output_select_two),
		.mem_standby(mem_standby), .port_a_in(port_a_in),
		.port_a_out_q(port_a_out_q), .port_a_oe(),
		.cfg_cs_open_drain(cfg_cs_open_drain), .cfg_secure(cfg_secure),
		.cfg_wr(cfg_wr), .cfg_idx(cfg_idx), .cfg_wdata(cfg_wdata),
		.prog_rd_req(prog_rd_req), .prog_rd_idx(prog_rd_idx),
		.prog_rd_data_q(prog_rd_data_q), .prog_rd_ack_q(prog_rd_ack_q),
		.prog_rd_refused_q(prog_rd_refused_q), .secure_locked(secure_locked));
	rss_host_model rss_host_model_i (.clk_sys(clk_sys),
		.decoder_select_outputs(decoder_select_outputs),
		.decoder_select_oe(decoder_select_oe),
		.eprom_bank_selects(eprom_bank_selects),
		.low_addr_data_lines(low_addr_data_lines), .ale(ale), .rd_n(rd_n),
		.wr_n(wr_n), .program_fetch_strobe_n(program_fetch_strobe_n),
		.high_addr_or_enable_pin(high_addr_or_enable_pin),
		.port_c_pins(port_c_pins), .cs_wire(cs_wire));
	// ----------------------------------------
	// helpers
	// ----------------------------------------
	task automatic chk_val(input logic [15:0] got, input logic [15:0] exp,
		input string what);
		n_checks++;
		if (got !== exp) begin
			miscompares++;
			$display("wrong value at %0t: %s got %h", $time, what, got);
		end
	endtask
	task automatic end_of_test;
		$display("checks %0d, mismatches %0d", n_checks, miscompares);
		if (miscompares == 0 && n_checks > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	// reset with the given strap, checks taken while held
	task automatic do_reset(input logic sec);
		@(negedge clk_sys);
		rst = 1'b1;
		cfg_secure = sec;
		repeat (3) @(negedge clk_sys);
		chk_val({5'h00, cs_wire}, 16'h07FF, "select pins");
		chk_val({3'h0, sram_select, port_space_select, periph_input_select,
			periph_output_select_one, periph_output_select_two,
			eprom_bank_selects}, 16'h0000, "internal selects");
		chk_val({8'h00, port_a_out_q}, 16'h0000, "port data");
		rst = 1'b0;
		repeat (3) @(negedge clk_sys);
	endtask
	task automatic cfg_write(input logic [3:0] idx, input logic [7:0] d);
		cfg_wr = 1'b1;
		cfg_idx = idx;
		cfg_wdata = d;
		@(negedge clk_sys);
		cfg_wr = 1'b0;
		@(negedge clk_sys);
	endtask
	// result packed as ack, refused, data
	task automatic readout(input logic [3:0] idx, input logic [15:0] exp);
		prog_rd_req = 1'b1;
		prog_rd_idx = idx;
		@(negedge clk_sys);
		prog_rd_req = 1'b0;
		chk_val({6'h00, prog_rd_ack_q, prog_rd_refused_q, prog_rd_data_q},
			exp, "readout");
		@(negedge clk_sys);
	endtask
	// bank 3 of eprom base 0, fetch or data read
	task automatic fetch(input logic use_rd, input logic [7:0] exp);
		rss_host_model_i.access({1'b0, use_rd}, 20'h03000, 8'h00, eb);
		chk_val({8'h00, eb}, {8'h00, exp}, "bank select");
	endtask
	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task automatic t_reset_values;
		do_reset(1'b0);
		chk_val({15'h0000, mem_standby}, 16'h0001, "standby");
		readout(4'hE, 16'h0200);
		cfg_write(4'hD, 8'h5A);
		readout(4'hD, 16'h025A);
		$display("reset values done");
	endtask
	task automatic t_space_select;
		fetch(1'b0, 8'h08);
		fetch(1'b1, 8'h00);
		cfg_write(4'hE, 8'h01);
		fetch(1'b1, 8'h08);
		fetch(1'b0, 8'h08);
		$display("space select done");
	endtask
	// port registers and sram over the host bus
	task automatic t_host_data;
		rss_host_model_i.access(2'h1, 20'h5A001, 8'h00, eb);
		chk_val(ad_out_q, 16'h0000, "data a after reset");
		rss_host_model_i.access(2'h2, 20'h5A001, 8'h3C, eb);
		rss_host_model_i.access(2'h1, 20'h5A001, 8'h00, eb);
		chk_val(ad_out_q, 16'h003C, "data a readback");
		chk_val({8'h00, port_a_out_q}, 16'h003C, "port a data");
		cfg_write(4'hC, 8'h20);
		rss_host_model_i.access(2'h2, 20'h20010, 8'h77, eb);
		rss_host_model_i.access(2'h1, 20'h20010, 8'h00, eb);
		chk_val(ad_out_q, 16'h0077, "sram readback");
		$display("host data done");
	endtask
	// peripheral region of select 2 with wait and port a tracking
	task automatic t_periph;
		cfg_write(4'h2, 8'h7E);
		cfg_write(4'hE, 8'h14);
		n_wait = 0;
		rss_host_model_i.access(2'h1, 20'h7E000, 8'h00, eb);
		chk_val(16'(n_wait), 16'h0004, "wait cycles");
		chk_val(ad_out_q, 16'h00A5, "tracked read");
		chk_val({8'h00, port_a_out_q}, 16'h00FF, "port a tracks");
		$display("peripheral done");
	endtask
	task automatic t_security;
		do_reset(1'b1);
		chk_val({15'h0000, secure_locked}, 16'h0001, "lock");
		readout(4'hE, 16'h0100);
		cfg_write(4'hE, 8'h01);
		fetch(1'b1, 8'h00);
		do_reset(1'b0);
		$display("security done");
	endtask
	// ----------------------------------------
	// clock, main sequence, watchdog
	// ----------------------------------------
	initial begin
		clk_sys = 1'b0;
		forever #10 clk_sys = ~clk_sys;
	end
	// cycles with the wait request raised
	always @(posedge clk_sys) begin
		if (wait_n === 1'b0) begin
			n_wait++;
		end
	end
	initial begin
		miscompares = 0;
		n_checks = 0;
		n_wait = 0;
		{rst, cfg_secure, cfg_wr, prog_rd_req} = 4'h8;
		{cfg_idx, prog_rd_idx, cfg_wdata} = 16'h0000;
		t_reset_values;
		t_space_select;
		t_host_data;
		t_periph;
		t_security;
		end_of_test;
	end
	initial begin
		#100000;
		miscompares++;
		end_of_test;
	end
endmodule // rss_top_tb
bind rss_top rss_monitor rss_monitor_i (.clk_sys(clk_sys), .rst(rst),
	.rd_n(rd_n), .wr_n(wr_n), .decoder_select_outputs(decoder_select_outputs),
	.decoder_select_oe(decoder_select_oe),
	.cfg_cs_open_drain(cfg_cs_open_drain),
	.eprom_bank_selects(eprom_bank_selects), .sram_select(sram_select),
	.port_space_select(port_space_select),
	.periph_input_select(periph_input_select),
	.periph_output_select_one(periph_output_select_one),
	.periph_output_select_two(periph_output_select_two),
	.mem_standby(mem_standby), .port_a_out_q(port_a_out_q),
	.ad_out_q(ad_out_q), .prog_rd_req(prog_rd_req),
	.prog_rd_data_q(prog_rd_data_q), .prog_rd_ack_q(prog_rd_ack_q),
	.prog_rd_refused_q(prog_rd_refused_q), .secure_locked(secure_locked));
